// [design/oppm_control.sv]
// Control word for over-current recovery, pulse gating and current monitor select
//
// Notes on behaviour
// - An over-current on a channel sets its over-current flag and switches that channel off.
// - Bits 15 to 11 let channels 7 to 11 switch back on by themselves after a delay, pulsing the current.
// - With recovery off, no single recovery happens; a tripped channel stays off until reset.
// - Bit 5 picks the recovery repetition rate, 1.7 kHz at zero and 3 kHz at one.
// - Bits 10 to 6 gate enabled channels 7 to 11 so each is on only while its pulse input is high.
// - Channels 8 and 10 follow pulse input b and all others follow pulse input a.
// - With bit 4 set, outputs stay off after a supply fault until the host clears the status.
// - Bits 3 to 0 route the chosen high-side channel's current image to the monitor pin, zero is channel 1.
// - A selector code that names no high-side channel switches the current monitor off.
`include "oppm_params.svh"
`timescale 1ns/100ps
`default_nettype none

module oppm_control #(
   parameter int SLOW_CYCLES = `OPPM_OCR_SLOW_CYCLES,
   parameter int FAST_CYCLES = `OPPM_OCR_FAST_CYCLES,
   parameter int CNT_W = 15
) (
   input wire logic mclk,                 // 50 MHz device clock
   input wire logic reset,                // Asynchronous, active high
   input wire logic ctrlWrite,            // One-cycle write strobe
   input wire logic [15:0] ctrlWrData,    // Word to store
   output logic [15:0] ctrlRdData,        // Stored control word
   input wire logic [4:0] channelEnable,  // Output enables, channels 7..11 (bit 0 = ch 7)
   input wire logic [4:0] overCurrent,    // Over-current detect, channels 7..11
   input wire logic pulseGateInputA,      // Pulse gate input a
   input wire logic pulseGateInputB,      // Pulse gate input b
   input wire logic supplyFault,          // Undervoltage or overvoltage level
   input wire logic statusClear,          // One-cycle status clear from host
   output logic [4:0] channelOn,          // Driver on, channels 7..11
   output logic [4:0] overCurrentFlag,    // Sticky over-current status
   output logic supplyLockout,            // Outputs held off after supply fault
   output logic [10:0] monitorSelect,     // One-hot image route, bit 0 = channel 1
   output logic monitorActive             // Current monitor switched on
);

   // Gate input per channel 7..11: b for 8 and 10, a otherwise
   localparam logic [4:0] GATE_USES_B = 5'h0A;

   oppm_pkg::oppm_ctrl_t ctrl_reg;
   oppm_pkg::oppm_ctrl_t ctrl_next;
   logic [CNT_W-1:0] recoveryCount_reg;
   logic [CNT_W-1:0] recoveryCount_next;
   logic recoveryTick;
   logic [4:0] tripped_reg;
   logic [4:0] recoveryEnableCh;
   logic [4:0] gateEnableCh;
   logic supplyLockout_reg;
   logic supplyOff;
   logic [4:0] gateOn;
   logic [4:0] channelOn_reg;
   logic [10:0] monitorSelect_reg;
   logic monitorActive_reg;
   logic [4:0] channelOn_next;

   function automatic logic [10:0] image_route(input logic [3:0] code);
      logic [10:0] route;
      route = 11'h000;
      if (code <= `OPPM_SEL_LAST) begin
         route[code] = 1'b1;
      end
      return route;
   endfunction : image_route

   // Control word storage
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrlWrite) begin
         ctrl_next = oppm_pkg::oppm_ctrl_t'(ctrlWrData);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= oppm_pkg::oppm_ctrl_t'(`OPPM_CTRL_RESET);
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   assign ctrlRdData = ctrl_reg;

   // Field bit order runs from channel 7 at the top; flip to channel order
   generate
      for (genvar i = 0; i < 5; i++) begin : g_map
         assign recoveryEnableCh[i] = ctrl_reg.recoveryEnable[4-i];
         assign gateEnableCh[i] = ctrl_reg.pulseGateEnable[4-i];
      end
   endgenerate

   // Free-running recovery phase, shared by all channels
   always_comb begin
      recoveryTick = 1'b0;
      recoveryCount_next = recoveryCount_reg + CNT_W'(1);
      if (ctrl_reg.recoveryFast) begin
         if (recoveryCount_reg >= CNT_W'(FAST_CYCLES - 1)) begin
            recoveryTick = 1'b1;
            recoveryCount_next = '0;
         end
      end else if (recoveryCount_reg >= CNT_W'(SLOW_CYCLES - 1)) begin
         recoveryTick = 1'b1;
         recoveryCount_next = '0;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         recoveryCount_reg <= '0;
      end else begin
         recoveryCount_reg <= recoveryCount_next;
      end
   end

   // Per-channel trip and recovery
   generate
      for (genvar i = 0; i < 5; i++) begin : g_trip
         oppm_pkg::oppm_ch_state_t state_reg;
         oppm_pkg::oppm_ch_state_t state_next;

         always_comb begin
            state_next = state_reg;
            unique case (state_reg)
               oppm_pkg::OPPM_CH_RUN: begin
                  if (overCurrent[i]) begin
                     state_next = oppm_pkg::OPPM_CH_TRIPPED;
                  end
               end
               oppm_pkg::OPPM_CH_TRIPPED: begin
                  // Released only on the shared phase, so retry pulses at the set rate
                  // No lone retry with recovery off: the channel stays off until reset
                  if (recoveryTick && recoveryEnableCh[i]) begin
                     state_next = oppm_pkg::OPPM_CH_RUN;
                  end
               end
               default: state_next = oppm_pkg::OPPM_CH_TRIPPED;
            endcase
         end

         always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
               state_reg <= oppm_pkg::OPPM_CH_RUN;
            end else begin
               state_reg <= state_next;
            end
         end

         assign tripped_reg[i] = (state_reg == oppm_pkg::OPPM_CH_TRIPPED);
      end
   endgenerate

   // Sticky over-current flags; a new event beats a clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         overCurrentFlag <= 5'h00;
      end else begin
         overCurrentFlag <= (statusClear ? 5'h00 : overCurrentFlag) | overCurrent;
      end
   end

   // Supply fault lockout, held until the host clears status
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         supplyLockout_reg <= 1'b0;
      end else if (supplyFault && ctrl_reg.supplyRestartOff) begin
         supplyLockout_reg <= 1'b1;
      end else if (statusClear) begin
         supplyLockout_reg <= 1'b0;
      end
   end

   assign supplyOff = supplyFault | supplyLockout_reg;
   assign supplyLockout = supplyLockout_reg;

   // Pulse gating by the assigned input
   generate
      for (genvar i = 0; i < 5; i++) begin : g_gate
         logic gateLevel;
         assign gateLevel = GATE_USES_B[i] ? pulseGateInputB : pulseGateInputA;
         assign gateOn[i] = ~gateEnableCh[i] | gateLevel;
      end
   endgenerate

   // Trip and the same-cycle detect both cut the driver
   assign channelOn_next = channelEnable & gateOn & ~tripped_reg & ~overCurrent
      & {5{~supplyOff}};

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         channelOn_reg <= 5'h00;
      end else begin
         channelOn_reg <= channelOn_next;
      end
   end

   assign channelOn = channelOn_reg;

   // Current image routing
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         monitorSelect_reg <= 11'h000;
      end else begin
         monitorSelect_reg <= image_route(ctrl_reg.imageSelect);
      end
   end

   // Own flop so the monitor enable never shows a decode glitch
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         monitorActive_reg <= 1'b0;
      end else begin
         monitorActive_reg <= |image_route(ctrl_reg.imageSelect);
      end
   end

   assign monitorSelect = monitorSelect_reg;
   assign monitorActive = monitorActive_reg;

endmodule : oppm_control

`default_nettype wire

// [pkg/oppm_params.svh]
// Constants for the protection, pulse gating and monitor control word
`ifndef OPPM_PARAMS_SVH
`define OPPM_PARAMS_SVH

`define OPPM_CTRL_WIDTH 16
`define OPPM_CTRL_RESET 16'h0000

`define OPPM_OCR_EN_MSB 15
`define OPPM_OCR_EN_LSB 11
`define OPPM_PWM_EN_MSB 10
`define OPPM_PWM_EN_LSB 6
`define OPPM_OCR_FREQ_BIT 5
`define OPPM_SUPPLY_RESTART_OFF_BIT 4
`define OPPM_SEL_MSB 3
`define OPPM_SEL_LSB 0

`define OPPM_CLK_HZ 50000000
`define OPPM_OCR_SLOW_HZ 1700
`define OPPM_OCR_FAST_HZ 3000
`define OPPM_OCR_SLOW_CYCLES (`OPPM_CLK_HZ / `OPPM_OCR_SLOW_HZ)
`define OPPM_OCR_FAST_CYCLES (`OPPM_CLK_HZ / `OPPM_OCR_FAST_HZ)

`define OPPM_SEL_LAST 4'hA
`define OPPM_MON_CHANNELS 11

`endif

// [pkg/oppm_pkg.sv]
// Types for the protection, pulse gating and monitor control word
package oppm_pkg;

   typedef struct packed {
      logic [4:0] recoveryEnable;   // Bit 15 = channel 7 ... bit 11 = channel 11
      logic [4:0] pulseGateEnable;  // Bit 10 = channel 7 ... bit 6 = channel 11
      logic recoveryFast;
      logic supplyRestartOff;
      logic [3:0] imageSelect;
   } oppm_ctrl_t;

   typedef enum logic [1:0] {
      OPPM_CH_RUN = 2'b00,
      OPPM_CH_TRIPPED = 2'b01
   } oppm_ch_state_t;

endpackage : oppm_pkg

// [sim/oppm_host.sv]
// Host model driving control writes and status clears
`timescale 1ns/100ps
`default_nettype none
module oppm_host (
   input wire logic mclk, // Clock
   output logic ctrlWrite, // Strobe
   output logic [15:0] ctrlWrData, // Word
   output logic statusClear // Clear pulse
);
   initial {ctrlWrite, ctrlWrData, statusClear} = '0;
   task put(input oppm_pkg::oppm_ctrl_t w);
      @(posedge mclk);
      #1 ctrlWrite = 1'b1;
      ctrlWrData = w;
      @(posedge mclk);
      #1 ctrlWrite = 1'b0;
      ctrlWrData = ~ctrlWrData; // Stale bus never shows the old word
   endtask : put
   task clear();
      @(posedge mclk);
      #1 statusClear = 1'b1;
      @(posedge mclk);
      #1 statusClear = 1'b0;
   endtask : clear
endmodule : oppm_host
`default_nettype wire

// [sim/oppm_checker.sv]
// Checker for trip, gating, lockout and monitor outputs
`timescale 1ns/100ps
`default_nettype none
module oppm_checker (
   input wire logic mclk, // Clock
   input wire logic reset, // Reset
   input wire logic ctrlWrite, // Strobe
   input wire logic [15:0] ctrlWrData, // Word
   input wire logic [15:0] ctrlRdData, // Stored
   input wire logic [4:0] overCurrent, // Detect
   input wire logic pulseGateInputA, // Gate a
   input wire logic pulseGateInputB, // Gate b
   input wire logic supplyFault, // Fault
   input wire logic [4:0] channelOn, // On
   input wire logic [4:0] overCurrentFlag, // Flags
   input wire logic supplyLockout, // Lockout
   input wire logic [10:0] monitorSelect, // Route
   input wire logic monitorActive // Monitor
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   chk_trip_off: assert property (|overCurrent |=> (channelOn & $past(overCurrent)) == 5'h00)
      else $error("tripped channel on");
   chk_trip_flag: assert property (|overCurrent |=>
      (overCurrentFlag & $past(overCurrent)) == $past(overCurrent)) else $error("flag not set");
   chk_word_back: assert property (ctrlWrite |=> ctrlRdData == $past(ctrlWrData))
      else $error("word not stored");
   chk_sel_route: assert property (ctrlRdData[3:0] <= 4'hA |=>
      monitorSelect == (11'h001 << $past(ctrlRdData[3:0])) && monitorActive) else $error("route");
   chk_sel_off: assert property (ctrlRdData[3:0] > 4'hA |=> monitorSelect == 11'h000
      && !monitorActive) else $error("monitor not off");
   chk_supply_off: assert property (supplyFault |=> channelOn == 5'h00)
      else $error("on during fault");
   chk_lock_set: assert property (supplyFault && ctrlRdData[4] |=> supplyLockout)
      else $error("no lockout");
   chk_gate_a: assert property (ctrlRdData[10] && !pulseGateInputA |=> !channelOn[0])
      else $error("gate a");
   chk_gate_b: assert property (ctrlRdData[9] && !pulseGateInputB |=> !channelOn[1])
      else $error("gate b");
endmodule : oppm_checker
bind oppm_control oppm_checker oppm_checker_inst (
   .mclk(mclk),
   .reset(reset),
   .ctrlWrite(ctrlWrite),
   .ctrlWrData(ctrlWrData),
   .ctrlRdData(ctrlRdData),
   .overCurrent(overCurrent),
   .pulseGateInputA(pulseGateInputA),
   .pulseGateInputB(pulseGateInputB),
   .supplyFault(supplyFault),
   .channelOn(channelOn),
   .overCurrentFlag(overCurrentFlag),
   .supplyLockout(supplyLockout),
   .monitorSelect(monitorSelect),
   .monitorActive(monitorActive)
);
`default_nettype wire

// [sim/oppm_control_bench.sv]
// Self-checking bench for the control word block
`timescale 1ns/100ps
`default_nettype none
module oppm_control_bench;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [4:0] channelEnable = 5'h00;
   logic [4:0] overCurrent = 5'h00;
   logic pulseGateInputA = 1'b0;
   logic pulseGateInputB = 1'b0;
   logic supplyFault = 1'b0;
   logic ctrlWrite, statusClear, supplyLockout, monitorActive;
   logic [15:0] ctrlWrData, ctrlRdData;
   logic [4:0] channelOn, overCurrentFlag;
   logic [10:0] monitorSelect;
   int badCount = 0;
   int compares = 0;
   int cyc = 0;
   int n, k;
   always #10 mclk = ~mclk;
   oppm_host oppm_host_inst (
      .mclk(mclk),
      .ctrlWrite(ctrlWrite),
      .ctrlWrData(ctrlWrData),
      .statusClear(statusClear)
   );
   // Short periods keep the run brief
   oppm_control #(.SLOW_CYCLES(20), .FAST_CYCLES(10)) oppm_control_inst (
      .mclk(mclk),
      .reset(reset),
      .ctrlWrite(ctrlWrite),
      .ctrlWrData(ctrlWrData),
      .ctrlRdData(ctrlRdData),
      .channelEnable(channelEnable),
      .overCurrent(overCurrent),
      .pulseGateInputA(pulseGateInputA),
      .pulseGateInputB(pulseGateInputB),
      .supplyFault(supplyFault),
      .statusClear(statusClear),
      .channelOn(channelOn),
      .overCurrentFlag(overCurrentFlag),
      .supplyLockout(supplyLockout),
      .monitorSelect(monitorSelect),
      .monitorActive(monitorActive)
   );
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         badCount++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task tick(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask : tick
   task wr(input logic [15:0] w);
      oppm_host_inst.put(w);
      chk(ctrlRdData, w);
   endtask : wr
   task giveVerdict();
      $display("compares %0d badCount %0d", compares, badCount);
      if (badCount == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : giveVerdict
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         badCount++;
         giveVerdict();
      end
   end
   initial begin
      tick(4);
      reset = 1'b0;
      tick(1);
      chk(ctrlRdData, 16'h0000);
      chk(16'(monitorSelect), 16'h0001);
      for (n = 0; n < 16; n++) begin
         wr({12'hFFF, 4'(n)});
         tick(1);
         chk(16'(monitorSelect), n < 11 ? 16'h0001 << n : 16'h0000);
         chk(16'(monitorActive), 16'(n < 11));
      end
      wr(16'h07C0);
      channelEnable = 5'h1F;
      for (n = 0; n < 4; n++) begin
         pulseGateInputA = n[0];
         pulseGateInputB = n[1];
         tick(2);
         chk(16'(channelOn), (n[0] ? 16'h0015 : 16'h0000) | (n[1] ? 16'h000A : 16'h0000));
      end
      channelEnable = 5'h1E;
      tick(2);
      chk(16'(channelOn), 16'h001E);
      channelEnable = 5'h1F;
      // Channel 8 has no recovery, so it stays tripped from here on
      for (n = 0; n < 2; n++) begin
         wr(n == 0 ? 16'h8020 : 16'h8000);
         overCurrent = 5'h03;
         tick(1);
         overCurrent = 5'h00;
         chk(16'(channelOn), 16'h001C);
         chk(16'(overCurrentFlag), 16'h0003);
         for (k = 0; k < 40 && channelOn[0] !== 1'b1; k++) tick(1);
         chk(16'(k <= (n == 0 ? 13 : 23)), 16'h0001);
         chk(16'(channelOn[1]), 16'h0000);
         oppm_host_inst.clear();
         chk(16'(overCurrentFlag), 16'h0000);
      end
      for (n = 0; n < 2; n++) begin
         wr(n == 0 ? 16'h0010 : 16'h0000);
         supplyFault = 1'b1;
         tick(2);
         supplyFault = 1'b0;
         tick(2);
         chk(16'(supplyLockout), 16'(n == 0));
         chk(16'(channelOn), n == 0 ? 16'h0000 : 16'h001D);
         oppm_host_inst.clear();
         tick(1);
         chk(16'(supplyLockout), 16'h0000);
         chk(16'(channelOn), 16'h001D);
      end
      // New event in the clear cycle must win; channel 9 has no recovery
      fork
         oppm_host_inst.clear();
         begin
            tick(1);
            overCurrent = 5'h04;
            tick(1);
            overCurrent = 5'h00;
         end
      join
      chk(16'(overCurrentFlag), 16'h0004);
      tick(1);
      chk(16'(channelOn), 16'h0019);
      giveVerdict();
   end
endmodule : oppm_control_bench
`default_nettype wire
